// ===== crl_cfg.svh
// constants for the condition-register logic, compare and leading-zero unit
// assumes big-endian bit numbering: bit 0 is the most significant bit
`ifndef CRL_CFG_SVH
`define CRL_CFG_SVH

// instruction fields (big-endian numbering, converted with 31-n)
`define CRL_OP_PRIMARY_CMPLI   6'h0A
`define CRL_OP_PRIMARY_CRLOG   6'h13
`define CRL_OP_PRIMARY_X       6'h1F
`define CRL_XO_CNTLZW          10'h01A
`define CRL_XO_CRAND           10'h101
`define CRL_XO_CRANDC          10'h081
`define CRL_XO_CREQV           10'h121
`define CRL_XO_CRNAND          10'h0E1
`define CRL_XO_CRNOR           10'h021
`define CRL_XO_CROR            10'h1C1
`define CRL_XO_CRORC           10'h1A1
`define CRL_XO_CRXOR           10'h0C1
`define CRL_IMM_EXT            16'h0000
`define CRL_CLZ_ALL_ZERO       6'h20
`define CRL_RECORD_FIELD       3'h0
`define CRL_CR_RESET           32'h00000000
`define CRL_GPR_RESET          32'h00000000

`endif

// ===== crl_dec_if.sv
// decoded-instruction bundle between the unit top and its decoder
// assumes one clock domain
`timescale 1ns/1ps
interface crl_dec_if;
   logic [31:0]        instr;
   crl_pkg::crl_op_type op;
   logic [4:0]         target_cr_bit;
   logic [4:0]         first_cr_bit;
   logic [4:0]         second_cr_bit;
   logic [2:0]         target_cr_field;
   logic [15:0]        unsigned_immediate;
   logic               record_bit;
   modport decoder (input instr, output op, target_cr_bit, first_cr_bit, second_cr_bit,
                    target_cr_field, unsigned_immediate, record_bit);
   modport unit (output instr, input op, target_cr_bit, first_cr_bit, second_cr_bit,
                 target_cr_field, unsigned_immediate, record_bit);
endinterface

// ===== crl_decoder.sv
// combinational instruction decoder for the unit
// assumes a 32-bit instruction word, bit 0 most significant
`timescale 1ns/1ps
`include "crl_cfg.svh"
module crl_decoder (
   crl_dec_if.decoder dec
);
   import crl_pkg::*;

   logic [5:0] primary;
   logic [9:0] ext_op;

   // fields in big-endian numbering: bits a..b map to [31-a:31-b]
   assign primary                = dec.instr[31:26];
   assign ext_op                 = dec.instr[10:1];  // bits 21-30
   assign dec.target_cr_bit      = dec.instr[25:21]; // bits 6-10
   assign dec.first_cr_bit       = dec.instr[20:16];
   assign dec.second_cr_bit      = dec.instr[15:11];
   assign dec.target_cr_field    = dec.instr[25:23];
   assign dec.unsigned_immediate = dec.instr[15:0];
   assign dec.record_bit         = dec.instr[0];

   // opcode selection
   always_comb begin
      dec.op = CRL_OP_NONE;
      if (primary == `CRL_OP_PRIMARY_CMPLI) begin
         dec.op = dec.instr[21] ? CRL_OP_INVALID : CRL_OP_CMP_UNSIGNED_IMMEDIATE; // operand-size bit
      end else if (primary == `CRL_OP_PRIMARY_CRLOG) begin
         unique case (ext_op)
            `CRL_XO_CRAND:  dec.op = CRL_OP_AND;
            `CRL_XO_CRANDC: dec.op = CRL_OP_AND_NOT;
            `CRL_XO_CREQV:  dec.op = CRL_OP_EQUIV;
            `CRL_XO_CRNAND: dec.op = CRL_OP_NAND;
            `CRL_XO_CRNOR:  dec.op = CRL_OP_NOR;
            `CRL_XO_CROR:   dec.op = CRL_OP_OR;
            `CRL_XO_CRORC:  dec.op = CRL_OP_OR_NOT;
            `CRL_XO_CRXOR:  dec.op = CRL_OP_XOR;
            default:        dec.op = CRL_OP_NONE;
         endcase
      end else if (primary == `CRL_OP_PRIMARY_X && ext_op == `CRL_XO_CNTLZW) begin
         dec.op = CRL_OP_CLZ;
      end
   end
endmodule

// ===== crl_pkg.sv
// types for the condition-register logic unit
// assumes crl_cfg.svh holds the numbers
package crl_pkg;
   typedef enum logic [3:0] {
      CRL_OP_NONE     = 4'h0,
      CRL_OP_CMP_UNSIGNED_IMMEDIATE = 4'h1,
      CRL_OP_CLZ      = 4'h2,
      CRL_OP_AND      = 4'h3,
      CRL_OP_NAND     = 4'h4,
      CRL_OP_OR       = 4'h5,
      CRL_OP_NOR      = 4'h6,
      CRL_OP_XOR      = 4'h7,
      CRL_OP_EQUIV    = 4'h8,
      CRL_OP_AND_NOT  = 4'h9,
      CRL_OP_OR_NOT   = 4'hA,
      CRL_OP_INVALID  = 4'hB
   } crl_op_type;
endpackage

// ===== crl_rf_model.sv
// condition register file model that feeds the unit
// assumes the bench loads a value one cycle before each issue
`timescale 1ns/1ps
module crl_rf_model (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   // bench load and unit writeback
   input  wire logic        load_in,
   input  wire logic [31:0] load_val_in,
   input  wire logic        cr_write_in,
   input  wire logic [31:0] cr_result_in,
   // operand to the unit
   output logic      [31:0] cr_out
);
   // state: a load from the bench wins over a writeback
   always_ff @(posedge clock_in) begin
      if (srst_in) cr_out <= 32'h00000000;
      else if (load_in) cr_out <= load_val_in;
      else if (cr_write_in) cr_out <= cr_result_in;
   end
endmodule

// ===== crl_unit.sv
// condition-register logic, unsigned-immediate compare and leading-zero count unit
// assumes operands arrive with the instruction in the same cycle; results one cycle later
`timescale 1ns/1ps
`include "crl_cfg.svh"
module crl_unit (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   // instruction issue
   input  wire logic        issue_valid_in,
   input  wire logic [31:0] instr_in,
   input  wire logic [31:0] gpr_operand_in,
   input  wire logic [31:0] cr_in,
   input  wire logic        summary_overflow_in,
   // results
   output logic             done_out,
   output logic             invalid_form_out,
   output logic             gpr_write_out,
   output logic [31:0]      gpr_result_out,
   output logic             cr_write_out,
   output logic [31:0]      cr_result_out
);
   import crl_pkg::*;

   crl_dec_if dec ();

   // decoded operands and next values of the registered results
   logic [31:0] cr_next;
   logic [31:0] clz_next;
   logic        cr_wr_next;
   logic        gpr_wr_next;
   logic [3:0]  field_flags;
   logic [31:0] imm_ext;
   logic        bit_a;
   logic        bit_b;
   logic        bit_res;
   logic [4:0]  tgt_pos;
   logic [4:0]  fld_pos;

   assign dec.instr = instr_in;

   crl_decoder u_dec (
      .dec (dec)
   );

   // condition bit i (bit 0 = msb) lives at vector index 31-i
   assign bit_a   = cr_in[5'd31 - dec.first_cr_bit];
   assign bit_b   = cr_in[5'd31 - dec.second_cr_bit];
   assign tgt_pos = 5'd31 - dec.target_cr_bit;
   assign imm_ext = {`CRL_IMM_EXT, dec.unsigned_immediate};

   // leading-zero count from the msb
   always_comb begin
      // the highest set bit is seen last, so it decides the count
      clz_next = {26'h0, `CRL_CLZ_ALL_ZERO}; // zero source gives 32
      for (int i = 0; i < 32; i++) begin
         if (gpr_operand_in[i]) begin
            clz_next = 32'(31 - i);
         end
      end
   end

   // bit logic result
   always_comb begin
      unique case (dec.op)
         CRL_OP_AND:     bit_res = bit_a & bit_b;
         CRL_OP_NAND:    bit_res = ~(bit_a & bit_b);
         CRL_OP_OR:      bit_res = bit_a | bit_b;
         CRL_OP_NOR:     bit_res = ~(bit_a | bit_b);
         CRL_OP_XOR:     bit_res = bit_a ^ bit_b;
         CRL_OP_EQUIV:   bit_res = ~(bit_a ^ bit_b);
         CRL_OP_AND_NOT: bit_res = bit_a & ~bit_b;
         CRL_OP_OR_NOT:  bit_res = bit_a | ~bit_b;
         default:        bit_res = 1'b0;
      endcase
   end

   // condition register next value
   // the whole register is returned so the caller writes it back without merging
   always_comb begin
      cr_next     = cr_in;
      cr_wr_next  = 1'b0;
      gpr_wr_next = 1'b0;
      field_flags = 4'h0;
      fld_pos     = 5'd28 - {dec.target_cr_field, 2'b00};
      if (issue_valid_in) begin
         unique case (dec.op)
            CRL_OP_CMP_UNSIGNED_IMMEDIATE: begin
               field_flags = {gpr_operand_in < imm_ext, gpr_operand_in > imm_ext,
                              gpr_operand_in == imm_ext, summary_overflow_in};
               cr_next[fld_pos +: 4] = field_flags;
               cr_wr_next = 1'b1;
            end
            CRL_OP_CLZ: begin
               gpr_wr_next = 1'b1;
               if (dec.record_bit) begin
                  // result is never negative, so less-than is cleared
                  field_flags = {1'b0, clz_next != 32'h00000000, clz_next == 32'h00000000,
                                 summary_overflow_in};
                  cr_next[31:28] = field_flags; // field 0
                  cr_wr_next = 1'b1;
               end
            end
            CRL_OP_AND, CRL_OP_NAND, CRL_OP_OR, CRL_OP_NOR, CRL_OP_XOR, CRL_OP_EQUIV,
            CRL_OP_AND_NOT, CRL_OP_OR_NOT: begin
               cr_next[tgt_pos] = bit_res;
               cr_wr_next = 1'b1;
            end
            default: begin
               cr_next = cr_in;
            end
         endcase
      end
   end

   // result registers
   // strobes are one-cycle pulses; data outputs hold between writes so a slow
   // consumer can still pick them up after the strobe has gone
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         done_out         <= 1'b0;
         invalid_form_out <= 1'b0;
         gpr_write_out    <= 1'b0;
         gpr_result_out   <= `CRL_GPR_RESET;
         cr_write_out     <= 1'b0;
         cr_result_out    <= `CRL_CR_RESET;
      end else begin
         done_out         <= issue_valid_in && dec.op != CRL_OP_NONE;
         invalid_form_out <= issue_valid_in && dec.op == CRL_OP_INVALID;
         gpr_write_out    <= gpr_wr_next;
         gpr_result_out   <= gpr_wr_next ? clz_next : gpr_result_out;
         cr_write_out     <= cr_wr_next;
         cr_result_out    <= cr_wr_next ? cr_next : cr_result_out;
      end
   end

   // assertions
   cmp_lt_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE && gpr_operand_in < {16'h0000, instr_in[15:0]}
      |=> cr_result_out[5'd31 - {$past(instr_in[25:23]), 2'b00}])
      else $error("compare less-than flag wrong");
   cmp_invalid_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && instr_in[31:26] == 6'h0A && instr_in[21] |=> invalid_form_out && !cr_write_out)
      else $error("invalid compare form not flagged");
   cmp_others_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE |=>
      ((cr_result_out ^ $past(cr_in)) & ~(32'hF0000000 >> {$past(instr_in[25:23]), 2'b00})) == 32'h0)
      else $error("compare touched another field");
   clz_zero_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ && gpr_operand_in == 32'h0 |=> gpr_result_out == 32'h20)
      else $error("zero source count not 32");
   clz_msb_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ && gpr_operand_in[31] |=> gpr_result_out == 32'h0)
      else $error("msb set count not 0");
   clz_record_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ |=> cr_write_out == $past(instr_in[0]) &&
      (!cr_write_out || (!cr_result_out[31] && cr_result_out[28] == $past(summary_overflow_in))))
      else $error("record field wrong");
   crand_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_AND |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ($past(cr_in[5'd31 - instr_in[20:16]]) & $past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit and wrong");
   crorc_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_OR_NOT |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ($past(cr_in[5'd31 - instr_in[20:16]]) | ~$past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit or-complement wrong");
   single_bit_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && instr_in[31:26] == 6'h13 && dec.op != CRL_OP_NONE |=>
      $countones(cr_result_out ^ $past(cr_in)) <= 1)
      else $error("bit op changed several bits");

   // compare: every flag of the chosen field, and nothing written to the gpr
   cmp_gt_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE && gpr_operand_in > {16'h0000, instr_in[15:0]}
      |=> cr_result_out[5'd30 - {$past(instr_in[25:23]), 2'b00}])
      else $error("compare greater flag wrong");
   cmp_eq_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE && gpr_operand_in == {16'h0000, instr_in[15:0]}
      |=> cr_result_out[5'd29 - {$past(instr_in[25:23]), 2'b00}])
      else $error("compare equal flag wrong");
   cmp_lt_clear_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE && gpr_operand_in >= {16'h0000, instr_in[15:0]}
      |=> !cr_result_out[5'd31 - {$past(instr_in[25:23]), 2'b00}])
      else $error("compare less-than flag set wrongly");
   cmp_onehot_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE
      |=> $onehot((cr_result_out << {$past(instr_in[25:23]), 2'b00}) & 32'hE0000000))
      else $error("compare flags not exclusive");
   cmp_so_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE
      |=> cr_result_out[5'd28 - {$past(instr_in[25:23]), 2'b00}] == $past(summary_overflow_in))
      else $error("compare summary flag wrong");
   cmp_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE |=> done_out && cr_write_out && !gpr_write_out)
      else $error("compare strobes wrong");

   // invalid compare form: reported, nothing written
   inval_quiet_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_INVALID |=> done_out && !gpr_write_out && $stable(cr_result_out))
      else $error("invalid form wrote a result");
   inval_flag_a: assert property (@(posedge clock_in) disable iff (srst_in)
      !(issue_valid_in && dec.op == CRL_OP_INVALID) |=> !invalid_form_out)
      else $error("invalid form flagged wrongly");

   // leading-zero count: range, first one bit and the zeros above it
   clz_range_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ |=> gpr_write_out && gpr_result_out <= 32'h00000020)
      else $error("count out of range");
   clz_lead_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ && gpr_operand_in != 32'h0 |=> gpr_result_out < 32'h00000020 &&
      (($past(gpr_operand_in) << gpr_result_out[4:0]) & 32'h80000000) != 32'h0)
      else $error("count does not stop at first one");
   clz_zeros_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ |=> ($past(gpr_operand_in) >> (6'd32 - gpr_result_out[5:0])) == 32'h0)
      else $error("count skips a one bit");
   clz_norec_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ && !instr_in[0] |=> !cr_write_out && $stable(cr_result_out))
      else $error("plain count changed a field");
   clz_rec_eq_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ && instr_in[0]
      |=> cr_result_out[30] == (gpr_result_out != 32'h0) && cr_result_out[29] == (gpr_result_out == 32'h0))
      else $error("record greater or equal flag wrong");
   clz_rec_rest_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_CLZ && instr_in[0] |=> cr_result_out[27:0] == $past(cr_in[27:0]))
      else $error("record form touched another field");

   // bit operations, one property per function
   crnand_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_NAND |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ~($past(cr_in[5'd31 - instr_in[20:16]]) & $past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit nand wrong");
   cror_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_OR |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ($past(cr_in[5'd31 - instr_in[20:16]]) | $past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit or wrong");
   crnor_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_NOR |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ~($past(cr_in[5'd31 - instr_in[20:16]]) | $past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit nor wrong");
   crxor_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_XOR |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ($past(cr_in[5'd31 - instr_in[20:16]]) ^ $past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit xor wrong");
   creqv_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_EQUIV |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ~($past(cr_in[5'd31 - instr_in[20:16]]) ^ $past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit equivalence wrong");
   crandc_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_AND_NOT |=> cr_result_out[5'd31 - $past(instr_in[25:21])] ==
      ($past(cr_in[5'd31 - instr_in[20:16]]) & ~$past(cr_in[5'd31 - instr_in[15:11]])))
      else $error("bit and-complement wrong");
   bitop_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && instr_in[31:26] == 6'h13 && dec.op != CRL_OP_NONE |=> cr_write_out && !gpr_write_out)
      else $error("bit op strobes wrong");

   // decode of the bit-operation extended opcodes and the compare form
   dec_and_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h101 |-> dec.op == CRL_OP_AND)
      else $error("bit and not decoded");
   dec_nand_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h0E1 |-> dec.op == CRL_OP_NAND)
      else $error("bit nand not decoded");
   dec_or_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h1C1 |-> dec.op == CRL_OP_OR)
      else $error("bit or not decoded");
   dec_nor_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h021 |-> dec.op == CRL_OP_NOR)
      else $error("bit nor not decoded");
   dec_xor_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h0C1 |-> dec.op == CRL_OP_XOR)
      else $error("bit xor not decoded");
   dec_eqv_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h121 |-> dec.op == CRL_OP_EQUIV)
      else $error("bit equivalence not decoded");
   dec_andc_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h081 |-> dec.op == CRL_OP_AND_NOT)
      else $error("bit and-complement not decoded");
   dec_orc_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h13 && instr_in[10:1] == 10'h1A1 |-> dec.op == CRL_OP_OR_NOT)
      else $error("bit or-complement not decoded");
   dec_cmp_a: assert property (@(posedge clock_in) disable iff (srst_in)
      instr_in[31:26] == 6'h0A && !instr_in[21] |-> dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE)
      else $error("valid compare form not decoded");

   // strobes are pulses and results hold between writes
   strobe_idle_a: assert property (@(posedge clock_in) disable iff (srst_in)
      !issue_valid_in |=> !done_out && !gpr_write_out && !cr_write_out && !invalid_form_out)
      else $error("strobe without an issue");
   none_quiet_a: assert property (@(posedge clock_in) disable iff (srst_in)
      issue_valid_in && dec.op == CRL_OP_NONE |=> !done_out && !cr_write_out && !gpr_write_out)
      else $error("unknown opcode executed");
   gpr_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
      !gpr_write_out |-> $stable(gpr_result_out))
      else $error("gpr result changed without a write");
   cr_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
      !cr_write_out |-> $stable(cr_result_out))
      else $error("cr result changed without a write");
   reset_zero_a: assert property (@(posedge clock_in)
      srst_in |=> !done_out && !cr_write_out && !gpr_write_out && cr_result_out == 32'h0)
      else $error("outputs not cleared by reset");

   cmp_c: cover property (@(posedge clock_in) issue_valid_in && dec.op == CRL_OP_CMP_UNSIGNED_IMMEDIATE);
   clz_rec_c: cover property (@(posedge clock_in) issue_valid_in && dec.op == CRL_OP_CLZ && instr_in[0]);
   xor_c: cover property (@(posedge clock_in) issue_valid_in && dec.op == CRL_OP_XOR);
   inval_c: cover property (@(posedge clock_in) invalid_form_out);
   clz_zero_c: cover property (@(posedge clock_in) issue_valid_in && dec.op == CRL_OP_CLZ && gpr_operand_in == 32'h0);
endmodule

// ===== tb_top.sv
// self-checking bench for the condition-register unit
// assumes results one cycle after the issue edge
`timescale 1ns/1ps
`include "crl_cfg.svh"
module tb_top;
   logic        clock_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        issue_valid_in = 1'b0;
   logic [31:0] instr_in = 32'h00000000;
   logic [31:0] gpr_operand_in = 32'h00000000;
   logic        summary_overflow_in = 1'b0;
   logic        load = 1'b0;
   logic [31:0] load_val = 32'h00000000;
   logic [31:0] cr_in;
   logic        done_out, invalid_form_out, gpr_write_out, cr_write_out;
   logic [31:0] gpr_result_out, cr_result_out;
   int          err_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   integer      seed = 32'h08624DFE;
   logic [9:0]  xo [8] = '{`CRL_XO_CRAND, `CRL_XO_CRNAND, `CRL_XO_CROR, `CRL_XO_CRNOR,
                           `CRL_XO_CRXOR, `CRL_XO_CREQV, `CRL_XO_CRANDC, `CRL_XO_CRORC};
   crl_unit dut (.clock_in(clock_in), .srst_in(srst_in), .issue_valid_in(issue_valid_in),
      .instr_in(instr_in), .gpr_operand_in(gpr_operand_in), .cr_in(cr_in),
      .summary_overflow_in(summary_overflow_in), .done_out(done_out),
      .invalid_form_out(invalid_form_out), .gpr_write_out(gpr_write_out),
      .gpr_result_out(gpr_result_out), .cr_write_out(cr_write_out), .cr_result_out(cr_result_out));
   crl_rf_model rf (.clock_in(clock_in), .srst_in(srst_in), .load_in(load), .load_val_in(load_val),
      .cr_write_in(cr_write_out), .cr_result_in(cr_result_out), .cr_out(cr_in));
   // clock and hang guard
   always #50 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         end_of_test();
      end
   end
   // reference for the eight bit operations, in xo table order
   function automatic logic bit_ref(int k, logic a, logic b);
      case (k)
         0: return a & b;
         1: return ~(a & b);
         2: return a | b;
         3: return ~(a | b);
         4: return a ^ b;
         5: return ~(a ^ b);
         6: return a & ~b;
         default: return a | ~b;
      endcase
   endfunction
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // load the register file, issue one word, then scramble the released inputs
   task automatic run(logic [31:0] cr, logic [31:0] ins, logic [31:0] opd, logic so);
      @(posedge clock_in);
      load <= 1'b1;
      load_val <= cr;
      @(posedge clock_in);
      load <= 1'b0;
      issue_valid_in <= 1'b1;
      instr_in <= ins;
      gpr_operand_in <= opd;
      summary_overflow_in <= so;
      @(posedge clock_in);
      issue_valid_in <= 1'b0;
      instr_in <= ~ins;
      gpr_operand_in <= ~opd;
      #1;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // main sequence
   initial begin
      logic [31:0] cr, opd, exp, r;
      logic [3:0]  c;
      int          n;
      repeat (6) @(posedge clock_in);
      srst_in <= 1'b0;
      #1;
      chk("reset strobes", {done_out, invalid_form_out, gpr_write_out, cr_write_out}, 0);
      chk("reset cr", cr_result_out, 0);
      for (int i = 0; i < 96; i++) begin
         cr = $random(seed);
         r = $random(seed);
         exp = cr;
         exp[31-r[4:0]] = bit_ref(i % 8, cr[31-r[9:5]], cr[31-r[14:10]]);
         run(cr, {`CRL_OP_PRIMARY_CRLOG, r[4:0], r[9:5], r[14:10], xo[i%8], 1'b0}, r, r[20]);
         chk("bitop strobes", {done_out, invalid_form_out, gpr_write_out, cr_write_out}, 4'h9);
         chk("bitop cr", cr_result_out, exp);
      end
      $display("bit operations done");
      for (int i = 0; i < 48; i++) begin
         cr = $random(seed);
         r = $random(seed);
         opd = (i % 4 == 3) ? $random(seed) : {16'h0000, r[15:0]} + (i % 4) - 1;
         c = (opd < {16'h0000, r[15:0]}) ? 4'h8 : (opd > {16'h0000, r[15:0]}) ? 4'h4 : 4'h2;
         c[0] = r[19];
         exp = cr;
         exp[31-4*r[18:16] -: 4] = c;
         run(cr, {`CRL_OP_PRIMARY_CMPLI, r[18:16], 1'b0, i >= 40, r[24:20], r[15:0]}, opd, r[19]);
         if (i >= 40) begin
            chk("bad form", {done_out, invalid_form_out, gpr_write_out, cr_write_out}, 4'hC);
         end else begin
            chk("cmp strobes", {done_out, invalid_form_out, gpr_write_out, cr_write_out}, 4'h9);
            chk("cmp cr", cr_result_out, exp);
         end
      end
      $display("compare done");
      for (int i = 0; i <= 32; i++) begin
         cr = $random(seed);
         r = $random(seed);
         opd = (r | 32'h80000000) >> i;
         n = i;
         exp = {1'b0, n != 0, n == 0, r[5], cr[27:0]};
         run(cr, {`CRL_OP_PRIMARY_X, r[10:6], r[15:11], 5'h00, `CRL_XO_CNTLZW, r[4]}, opd, r[5]);
         chk("clz strobes", {done_out, invalid_form_out, gpr_write_out, cr_write_out}, {3'h5, r[4]});
         chk("clz count", gpr_result_out, n);
         if (r[4]) chk("clz cr", cr_result_out, exp);
      end
      $display("leading zero count done");
      run($random(seed), {6'h00, 26'h3FFFFFF}, $random(seed), 1'b1);
      chk("unknown strobes", {done_out, invalid_form_out, gpr_write_out, cr_write_out}, 0);
      $display("unknown opcode done");
      end_of_test();
   end
endmodule
